// ===== gied_pkg.sv
// Shared constants, encodings and carrier types for the guest exit decider.
package gied_pkg;

  // Register map, byte addresses on the bus.
  localparam logic [7:0] GIED_ADDR_CTRL = 8'h00;
  localparam logic [7:0] GIED_ADDR_OFS_LO = 8'h04;
  localparam logic [7:0] GIED_ADDR_OFS_HI = 8'h08;
  localparam logic [7:0] GIED_ADDR_XBM_LO = 8'h0C;
  localparam logic [7:0] GIED_ADDR_XBM_HI = 8'h10;
  localparam logic [7:0] GIED_ADDR_MASK_LO = 8'h14;
  localparam logic [7:0] GIED_ADDR_MASK_HI = 8'h18;
  localparam logic [7:0] GIED_ADDR_SHD_LO = 8'h1C;
  localparam logic [7:0] GIED_ADDR_SHD_HI = 8'h20;
  localparam logic [7:0] GIED_ADDR_STATUS = 8'h24;

  // Execution control bits in the control register.
  localparam int GIED_CTRL_TS_EXIT = 0;
  localparam int GIED_CTRL_TS_OFS = 1;
  localparam int GIED_CTRL_PAIR_EN = 2;
  localparam int GIED_CTRL_SUP_EN = 3;
  localparam int GIED_CTRL_EXT_EXIT = 4;
  localparam int GIED_CTRL_NMI_EXIT = 5;
  localparam int GIED_CTRL_EXTENDED_INTERRUPT_CONTROLLER = 6;
  localparam int GIED_CTRL_W = 7;
  localparam logic [GIED_CTRL_W-1:0] GIED_CTRL_RST = 7'h00;
  localparam logic [31:0] GIED_WORD_RST = 32'h0000_0000;

  // Model register indices with special treatment in the guest.
  localparam logic [31:0] GIED_MREG_TSC = 32'h0000_0010;
  localparam logic [31:0] GIED_MREG_UCODE = 32'h0000_0079;
  localparam logic [31:0] GIED_MREG_DEADLINE = 32'h0000_06E0;
  localparam logic [31:0] GIED_MREG_LOCAL_INTERRUPT_CONTROLLER_LO = 32'h0000_0800;
  localparam logic [31:0] GIED_MREG_LOCAL_INTERRUPT_CONTROLLER_HI = 32'h0000_08FF;
  localparam logic [31:0] GIED_MREG_TPR = 32'h0000_0808;
  localparam logic [31:0] GIED_MREG_EOI = 32'h0000_080B;
  localparam logic [31:0] GIED_MREG_SELF = 32'h0000_083F;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_RD_TS = 4'h1, OP_RD_TS_PAIR = 4'h2, OP_MREG_RD = 4'h3,
    OP_MREG_WR = 4'h4, OP_STORE_MW = 4'h5, OP_SUP_SAVE = 4'h6,
    OP_SUP_RESTORE = 4'h7, OP_TASK_SW = 4'h8
  } gied_op_t;

  typedef enum logic [2:0] {
    OUT_NORMAL = 3'h0, OUT_ALTERED = 3'h1, OUT_INV_OPCODE = 3'h2, OUT_EXIT = 3'h3,
    OUT_GP_FAULT = 3'h4, OUT_PAGE_FAULT = 3'h5, OUT_LOCAL_INTERRUPT_CONTROLLER_VIRT = 3'h6
  } gied_outcome_t;

  typedef enum logic [1:0] {
    DW_MEM = 2'h0, DW_REG16 = 2'h1, DW_REG32 = 2'h2, DW_REG64 = 2'h3
  } gied_dwidth_t;

  // Origin of a task switch attempt.
  typedef enum logic [2:0] {
    TS_SW_GATE = 3'h0, TS_BPOF_GATE = 3'h1, TS_DIRECT = 3'h2, TS_HW_GATE = 3'h3,
    TS_RET_NESTED = 3'h4
  } gied_ts_src_t;

  typedef struct packed {
    gied_op_t op;
    logic [31:0] index;
    logic [63:0] operand;
    gied_dwidth_t width;
    logic [63:0] dest_old;
  } gied_req_t;

  typedef struct packed {
    logic [63:0] timestamp_counter;
    logic [63:0] tsc_aux;
    logic [63:0] deadline;
    logic [63:0] cr0;
    logic [63:0] sup_mask;
    logic [63:0] mreg_rdata;
  } gied_state_t;

  typedef struct packed {
    gied_ts_src_t src;
    logic long_mode;
    logic gate_present;
    logic gate_priv_ok;
    logic desc_priv_ok;
    logic sel_in_limit;
    logic desc_page_ok;
    logic desc_fields_ok;
  } gied_task_t;

  typedef struct packed {
    gied_outcome_t outcome;
    logic [63:0] data;
    logic [31:0] count;
    logic count_we;
    logic ucode_load;
    logic vect_valid;
    logic intr_info_valid;
  } gied_resp_t;

endpackage

// ===== gied_store_word.sv
// Merge of control register zero and its read shadow for the machine-word store.
`timescale 1ns/1ps
module gied_store_word (
  // Sources
  input wire logic [63:0] cr0,
  input wire logic [63:0] mask,
  input wire logic [63:0] shadow,
  // Destination
  input wire gied_pkg::gied_dwidth_t width,
  input wire logic [63:0] dest_old,
  output logic [63:0] result
);
  import gied_pkg::*;

  logic [63:0] merged;

  assign merged = (cr0 & ~mask) | (shadow & mask); // [RULE_09]

  always_comb begin
    unique case (width)
      DW_MEM, DW_REG16: result = {dest_old[63:16], merged[15:0]}; // [RULE_10]
      DW_REG32: result = {32'h0000_0000, merged[31:0]}; // [RULE_11]
      DW_REG64: result = merged;
    endcase
  end

endmodule // gied_store_word

// ===== gied_task_check.sv
// Ordered checks made before a guest task switch may become a guest exit.
`timescale 1ns/1ps
module gied_task_check (
  // Attempt description
  input wire gied_pkg::gied_task_t task_in,
  // Verdict
  output gied_pkg::gied_outcome_t verdict
);
  import gied_pkg::*;

  logic via_gate;
  logic priv_gate;
  logic priv_desc;
  logic step1_ok;

  assign via_gate = (task_in.src == TS_SW_GATE) || (task_in.src == TS_BPOF_GATE)
                    || (task_in.src == TS_HW_GATE);
  // Hardware events through the table carry no privilege checks.
  assign priv_gate = (task_in.src == TS_SW_GATE) || (task_in.src == TS_BPOF_GATE); // [RULE_21]
  assign priv_desc = (task_in.src == TS_DIRECT); // [RULE_21]
  assign step1_ok = (!via_gate || task_in.gate_present)
                    && (!priv_gate || task_in.gate_priv_ok)
                    && (!priv_desc || task_in.desc_priv_ok);

  // Checks run in order; the first failure decides the fault.
  always_comb begin
    if (task_in.long_mode) begin
      verdict = OUT_GP_FAULT; // [RULE_20]
    end else if (!step1_ok) begin
      verdict = OUT_GP_FAULT; // [RULE_19]
    end else if (!task_in.sel_in_limit) begin
      verdict = OUT_GP_FAULT; // [RULE_19]
    end else if (!task_in.desc_page_ok) begin
      verdict = OUT_PAGE_FAULT; // [RULE_19]
    end else if (!task_in.desc_fields_ok) begin
      verdict = OUT_GP_FAULT; // [RULE_19]
    end else begin
      verdict = OUT_EXIT; // [RULE_18]
    end
  end

endmodule // gied_task_check

// ===== gied_top.sv
// Guest instruction exit decider with its register slave and event blocking.
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// [RULE_01] Guest read of the timer deadline register returns the raw, unoffset deadline.
// [RULE_02] Reads of indices 800H-8FFH are handed to interrupt virtualization when enabled.
// [RULE_03] Both timestamp controls clear: read_timestamp runs normally.
// [RULE_04] Offsetting only: read_timestamp returns counter plus signed offset.
// [RULE_05] Timestamp exiting set: read_timestamp always causes a guest exit.
// [RULE_06] Pair read disabled: read_timestamp_pair raises the invalid opcode fault.
// [RULE_07] Pair with offsetting: offset sum plus count register from aux bits 31:0.
// [RULE_08] Pair with exiting set exits; with both controls clear runs normally.
// [RULE_09] Machine-word store takes masked bits from shadow, the rest from register zero.
// [RULE_10] Memory or 16-bit destination: low 16 bits used, bits 63:16 kept.
// [RULE_11] 32-bit destination: low 32 bits used, bits 63:32 cleared.
// [RULE_12] Write to microcode update trigger loads nothing and simply continues.
// [RULE_13] Writes to 808H, 80BH, 83FH go to interrupt virtualization when enabled.
// [RULE_14] Supervisor save/restore disabled: both raise the invalid opcode fault.
// [RULE_15] Enabled: exit when operand, state mask and bitmap share a set bit.
// [RULE_16] External interrupt exiting: interrupt enable flag stops gating, interrupts exit.
// [RULE_17] With exiting set, set-flag and stack-load shadows still block events.
// [RULE_18] Any guest task switch ends in a guest exit when checks pass.
// [RULE_19] Gate, selector, descriptor read, descriptor fields checked in order first.
// [RULE_20] Long mode task gates, direct task descriptors, nested return: protection fault.
// [RULE_21] Outside long mode privilege checks follow the gate or direct access path.
// [RULE_22] Exit through a table gate records vectoring; interruption info valid is zero.
module gied_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Instruction decision request and answer
  input wire logic req_valid,
  input wire gied_pkg::gied_req_t req,
  input wire gied_pkg::gied_state_t mstate,
  input wire gied_pkg::gied_task_t task_in,
  output logic resp_valid,
  output gied_pkg::gied_resp_t resp,
  // Event blocking
  input wire logic ext_irq_pending,
  input wire logic nmi_pending,
  input wire logic interrupt_enable_flag,
  input wire logic flag_set_shadow,
  input wire logic stack_load_shadow,
  input wire logic other_block,
  output logic ext_irq_deliver,
  output logic ext_irq_exit,
  output logic nmi_deliver,
  output logic nmi_exit
);
  import gied_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register file and bus slave

  logic [GIED_CTRL_W-1:0] ctrl_reg;
  logic [63:0] ofs_reg;
  logic [63:0] xbm_reg;
  logic [63:0] mask_reg;
  logic [63:0] shd_reg;
  logic [15:0] exit_cnt_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic addr_take;

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = GIED_WORD_RST;
    unique case (a)
      GIED_ADDR_CTRL: v = {25'h000_0000, ctrl_reg};
      GIED_ADDR_OFS_LO: v = ofs_reg[31:0];
      GIED_ADDR_OFS_HI: v = ofs_reg[63:32];
      GIED_ADDR_XBM_LO: v = xbm_reg[31:0];
      GIED_ADDR_XBM_HI: v = xbm_reg[63:32];
      GIED_ADDR_MASK_LO: v = mask_reg[31:0];
      GIED_ADDR_MASK_HI: v = mask_reg[63:32];
      GIED_ADDR_SHD_LO: v = shd_reg[31:0];
      GIED_ADDR_SHD_HI: v = shd_reg[63:32];
      GIED_ADDR_STATUS: v = {13'h0000, resp.outcome, exit_cnt_reg};
      default: v = GIED_WORD_RST;
    endcase
    return v;
  endfunction

  // Upper address bits are ignored, so the map repeats every 256 bytes.
  assign addr_take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= GIED_WORD_RST;
    end else begin
      wr_pend_reg <= addr_take && hwrite;
      if (addr_take) begin
        wr_addr_reg <= {haddr[7:2], 2'b00};
      end
      if (addr_take && !hwrite) begin
        hrdata_reg <= reg_read({haddr[7:2], 2'b00});
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= GIED_CTRL_RST;
      ofs_reg <= {GIED_WORD_RST, GIED_WORD_RST};
      xbm_reg <= {GIED_WORD_RST, GIED_WORD_RST};
      mask_reg <= {GIED_WORD_RST, GIED_WORD_RST};
      shd_reg <= {GIED_WORD_RST, GIED_WORD_RST};
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        GIED_ADDR_CTRL: ctrl_reg <= hwdata[GIED_CTRL_W-1:0];
        GIED_ADDR_OFS_LO: ofs_reg[31:0] <= hwdata;
        GIED_ADDR_OFS_HI: ofs_reg[63:32] <= hwdata;
        GIED_ADDR_XBM_LO: xbm_reg[31:0] <= hwdata;
        GIED_ADDR_XBM_HI: xbm_reg[63:32] <= hwdata;
        GIED_ADDR_MASK_LO: mask_reg[31:0] <= hwdata;
        GIED_ADDR_MASK_HI: mask_reg[63:32] <= hwdata;
        GIED_ADDR_SHD_LO: shd_reg[31:0] <= hwdata;
        GIED_ADDR_SHD_HI: shd_reg[63:32] <= hwdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decision

  logic c_ts_exit;
  logic c_ts_ofs;
  logic c_pair_en;
  logic c_sup_en;
  logic c_extended_interrupt_controller;
  logic [63:0] ts_sum;
  logic [63:0] mw_result;
  gied_outcome_t task_verdict;
  gied_resp_t resp_next;

  function automatic logic in_local_interrupt_controller_range(input logic [31:0] idx);
    return (idx >= GIED_MREG_LOCAL_INTERRUPT_CONTROLLER_LO) && (idx <= GIED_MREG_LOCAL_INTERRUPT_CONTROLLER_HI);
  endfunction

  function automatic logic is_local_interrupt_controller_write(input logic [31:0] idx);
    return (idx == GIED_MREG_TPR) || (idx == GIED_MREG_EOI) || (idx == GIED_MREG_SELF);
  endfunction

  assign c_ts_exit = ctrl_reg[GIED_CTRL_TS_EXIT];
  assign c_ts_ofs = ctrl_reg[GIED_CTRL_TS_OFS];
  assign c_pair_en = ctrl_reg[GIED_CTRL_PAIR_EN];
  assign c_sup_en = ctrl_reg[GIED_CTRL_SUP_EN];
  assign c_extended_interrupt_controller = ctrl_reg[GIED_CTRL_EXTENDED_INTERRUPT_CONTROLLER];
  // Two's complement addition is the signed sum; carry out of bit 63 is dropped.
  assign ts_sum = mstate.timestamp_counter + ofs_reg; // [RULE_04]

  gied_store_word u_store_word (
    .cr0(mstate.cr0),
    .mask(mask_reg),
    .shadow(shd_reg),
    .width(req.width),
    .dest_old(req.dest_old),
    .result(mw_result)
  );

  gied_task_check u_task_check (
    .task_in(task_in),
    .verdict(task_verdict)
  );

  always_comb begin
    resp_next = '0;
    resp_next.outcome = OUT_NORMAL;
    unique case (req.op)
      OP_RD_TS: begin
        if (c_ts_exit) begin
          resp_next.outcome = OUT_EXIT; // [RULE_05]
        end else if (c_ts_ofs) begin
          resp_next.outcome = OUT_ALTERED;
          resp_next.data = ts_sum; // [RULE_04]
        end else begin
          resp_next.data = mstate.timestamp_counter; // [RULE_03]
        end
      end
      OP_RD_TS_PAIR: begin
        if (!c_pair_en) begin
          resp_next.outcome = OUT_INV_OPCODE; // [RULE_06]
        end else if (c_ts_exit) begin
          resp_next.outcome = OUT_EXIT; // [RULE_08]
        end else begin
          resp_next.outcome = c_ts_ofs ? OUT_ALTERED : OUT_NORMAL;
          resp_next.data = c_ts_ofs ? ts_sum : mstate.timestamp_counter; // [RULE_07] [RULE_08]
          resp_next.count = mstate.tsc_aux[31:0]; // [RULE_07]
          resp_next.count_we = 1'b1;
        end
      end
      OP_MREG_RD: begin
        if (req.index == GIED_MREG_DEADLINE) begin
          resp_next.data = mstate.deadline; // [RULE_01]
        end else if (req.index == GIED_MREG_TSC && c_ts_ofs) begin
          resp_next.outcome = OUT_ALTERED;
          resp_next.data = ts_sum;
        end else if (in_local_interrupt_controller_range(req.index) && c_extended_interrupt_controller) begin
          resp_next.outcome = OUT_LOCAL_INTERRUPT_CONTROLLER_VIRT; // [RULE_02]
        end else begin
          resp_next.data = mstate.mreg_rdata;
        end
      end
      OP_MREG_WR: begin
        if (req.index == GIED_MREG_UCODE) begin
          resp_next.outcome = OUT_ALTERED;
          resp_next.ucode_load = 1'b0; // [RULE_12]
        end else if (is_local_interrupt_controller_write(req.index) && c_extended_interrupt_controller) begin
          resp_next.outcome = OUT_LOCAL_INTERRUPT_CONTROLLER_VIRT; // [RULE_13]
        end
      end
      OP_STORE_MW: begin
        resp_next.outcome = OUT_ALTERED;
        resp_next.data = mw_result; // [RULE_09]
      end
      OP_SUP_SAVE, OP_SUP_RESTORE: begin
        if (!c_sup_en) begin
          resp_next.outcome = OUT_INV_OPCODE; // [RULE_14]
        end else if ((req.operand & mstate.sup_mask & xbm_reg) != 64'h0) begin
          resp_next.outcome = OUT_EXIT; // [RULE_15]
        end
      end
      OP_TASK_SW: begin
        resp_next.outcome = task_verdict; // [RULE_18]
        // The originating event is recorded only when a hardware event came through a table gate.
        resp_next.vect_valid = (task_in.src == TS_HW_GATE); // [RULE_22]
        resp_next.intr_info_valid = 1'b0; // [RULE_22]
      end
      default: ;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_valid <= 1'b0;
      resp <= '0;
    end else begin
      resp_valid <= req_valid;
      if (req_valid) begin
        resp <= resp_next;
      end
    end
  end

  // The counter wraps; software reads differences, not absolute totals.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exit_cnt_reg <= 16'h0000;
    end else if (req_valid && resp_next.outcome == OUT_EXIT) begin
      exit_cnt_reg <= exit_cnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event blocking

  logic shadow_blk;
  logic c_ext_exit;
  logic c_nmi_exit;

  // Instruction shadows keep blocking even while exiting is on.
  assign shadow_blk = flag_set_shadow || stack_load_shadow || other_block; // [RULE_17]
  assign c_ext_exit = ctrl_reg[GIED_CTRL_EXT_EXIT];
  assign c_nmi_exit = ctrl_reg[GIED_CTRL_NMI_EXIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_irq_deliver <= 1'b0;
      ext_irq_exit <= 1'b0;
      nmi_deliver <= 1'b0;
      nmi_exit <= 1'b0;
    end else begin
      ext_irq_exit <= c_ext_exit && ext_irq_pending && !shadow_blk; // [RULE_16]
      ext_irq_deliver <= !c_ext_exit && ext_irq_pending && !shadow_blk
                         && interrupt_enable_flag;
      nmi_exit <= c_nmi_exit && nmi_pending && !shadow_blk; // [RULE_17]
      nmi_deliver <= !c_nmi_exit && nmi_pending && !shadow_blk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_ts_exit_wins: assert property ( // [RULE_05]
    req_valid && req.op == OP_RD_TS && c_ts_exit |=> resp_valid && resp.outcome == OUT_EXIT)
    else $error("timestamp read did not exit");
  a_ts_offset_sum: assert property ( // [RULE_04]
    req_valid && req.op == OP_RD_TS && !c_ts_exit && c_ts_ofs
    |=> resp.data == $past(mstate.timestamp_counter) + $past(ofs_reg))
    else $error("offset timestamp sum wrong");
  a_pair_disabled: assert property ( // [RULE_06]
    req_valid && req.op == OP_RD_TS_PAIR && !c_pair_en |=> resp.outcome == OUT_INV_OPCODE)
    else $error("disabled pair read did not fault");
  a_pair_aux_load: assert property ( // [RULE_07]
    req_valid && req.op == OP_RD_TS_PAIR && c_pair_en && !c_ts_exit
    |=> resp.count_we && resp.count == $past(mstate.tsc_aux[31:0]))
    else $error("pair read aux word wrong");
  a_deadline_raw: assert property ( // [RULE_01]
    req_valid && req.op == OP_MREG_RD && req.index == GIED_MREG_DEADLINE
    |=> resp.data == $past(mstate.deadline))
    else $error("deadline read was offset");
  a_ucode_no_load: assert property ( // [RULE_12]
    req_valid && req.op == OP_MREG_WR && req.index == GIED_MREG_UCODE
    |=> !resp.ucode_load && resp.outcome == OUT_ALTERED)
    else $error("microcode trigger not ignored");
  a_store_upper32: assert property ( // [RULE_11]
    req_valid && req.op == OP_STORE_MW && req.width == DW_REG32 |=> resp.data[63:32] == 32'h0)
    else $error("upper half not cleared");
  a_store_upper16: assert property ( // [RULE_10]
    req_valid && req.op == OP_STORE_MW && req.width == DW_REG16
    |=> resp.data[63:16] == $past(req.dest_old[63:16]))
    else $error("upper bits not kept");
  a_sup_disabled: assert property ( // [RULE_14]
    req_valid && (req.op == OP_SUP_SAVE || req.op == OP_SUP_RESTORE) && !c_sup_en
    |=> resp.outcome == OUT_INV_OPCODE)
    else $error("supervisor op did not fault");
  a_irq_ignores_flag: assert property ( // [RULE_16]
    c_ext_exit && ext_irq_pending && !shadow_blk && !interrupt_enable_flag
    |=> ext_irq_exit && !ext_irq_deliver)
    else $error("external interrupt not exiting");
  a_task_vectoring: assert property ( // [RULE_22]
    req_valid && req.op == OP_TASK_SW && task_in.src == TS_HW_GATE
    |=> resp.vect_valid && !resp.intr_info_valid)
    else $error("task gate vectoring wrong");

  c_ts_offset: cover property (req_valid && req.op == OP_RD_TS && c_ts_ofs && !c_ts_exit);
  c_sup_exit: cover property (req_valid && req.op == OP_SUP_SAVE ##1 resp.outcome == OUT_EXIT);
  c_task_exit: cover property (req_valid && req.op == OP_TASK_SW ##1 resp.outcome == OUT_EXIT);
  c_irq_exit: cover property (ext_irq_exit);

endmodule // gied_top

// ===== gied_top_bench.sv
// Self-checking bench for the guest exit decider: bus setup, requests and event blocking.
`timescale 1ns/1ps
module gied_top_bench;
  import gied_pkg::*;
  logic hclk, hresetn, hsel, hwrite, req_valid, rdy_q;
  logic [31:0] haddr, hwdata, rd_q, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire hready;
  logic hreadyout, hresp, resp_valid;
  logic [31:0] hrdata;
  gied_req_t req;
  gied_state_t mstate;
  gied_task_t task_in;
  gied_resp_t resp;
  logic ext_irq_pending, nmi_pending, interrupt_enable_flag, flag_set_shadow;
  logic stack_load_shadow, other_block, ext_irq_deliver, ext_irq_exit, nmi_deliver, nmi_exit;
  int num_errors = 0;
  int total_checks = 0;
  int n_exit = 0;
  logic [63:0] m, mk, sh, old;
  assign hready = hreadyout;
  gied_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid), .req(req), .mstate(mstate),
    .task_in(task_in), .resp_valid(resp_valid), .resp(resp), .ext_irq_pending(ext_irq_pending),
    .nmi_pending(nmi_pending), .interrupt_enable_flag(interrupt_enable_flag),
    .flag_set_shadow(flag_set_shadow), .stack_load_shadow(stack_load_shadow),
    .other_block(other_block), .ext_irq_deliver(ext_irq_deliver), .ext_irq_exit(ext_irq_exit),
    .nmi_deliver(nmi_deliver), .nmi_exit(nmi_exit));
  initial begin
    hclk = 0;
    forever #2.5 hclk = ~hclk;
  end
  // Sampling through a flop avoids racing the design's own updates at the edge.
  always @(posedge hclk) begin
    rd_q <= hrdata;
    rdy_q <= hreadyout;
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  // A slave that never answers is left to the watchdog, so a hang counts as a failure.
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= wr; hsize <= 3'h2;
    do begin @(posedge hclk); #1; end while (rdy_q !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do begin @(posedge hclk); #1; end while (rdy_q !== 1'b1);
    q = rd_q;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
    chk(hresp, 1'b0);
  endtask
  task rq(input gied_op_t op, input logic [31:0] idx, input logic [63:0] opnd,
      input gied_dwidth_t w, input gied_outcome_t ex);
    req <= '{op, idx, opnd, w, old}; req_valid <= 1'b1;
    @(posedge hclk); #1;
    req_valid <= 1'b0;
    chk(resp_valid, 1'b1);
    chk(resp.outcome, ex);
    if (ex == OUT_EXIT) n_exit++;
    @(posedge hclk); #1;
    chk(resp_valid, 1'b0);
  endtask
  task ts(input gied_ts_src_t s, input logic [6:0] b, input gied_outcome_t ex);
    task_in <= {s, b};
    rq(OP_TASK_SW, 32'h0, 64'h0, DW_REG64, ex);
    chk(resp.vect_valid, s == TS_HW_GATE);
    chk(resp.intr_info_valid, 1'b0);
  endtask
  task ev(input logic e, input logic f, input logic sh2, input logic [3:0] ex);
    ext_irq_pending <= e; nmi_pending <= e; interrupt_enable_flag <= f;
    flag_set_shadow <= sh2;
    @(posedge hclk); #1;
    chk({ext_irq_deliver, ext_irq_exit, nmi_deliver, nmi_exit}, ex);
  endtask
  task summarize;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  initial begin
    hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
    req_valid = 0; req = '0; task_in = '0; old = 64'h0123_4567_89AB_CDEF;
    mstate = '{64'h0000_0001_FFFF_FFF0, 64'hAAAA_BBBB_1234_5678, 64'h0000_0005_0000_0000,
      64'h1234_5678_9ABC_DEF0, 64'h0000_0000_0000_0300, 64'h0000_0000_0000_5555};
    ext_irq_pending = 0; nmi_pending = 0; interrupt_enable_flag = 0;
    flag_set_shadow = 0; stack_load_shadow = 0; other_block = 0;
    repeat (6) @(posedge hclk);
    #1 hresetn = 1;
    rd(GIED_ADDR_CTRL, 32'h0);
    rd(GIED_ADDR_OFS_LO, 32'h0);
    // Offset of minus sixteen lowers the counter's low word without a borrow into the upper half.
    xfer(1'b1, GIED_ADDR_OFS_LO, 32'hFFFF_FFF0);
    xfer(1'b1, GIED_ADDR_OFS_HI, 32'hFFFF_FFFF);
    rd(GIED_ADDR_OFS_LO, 32'hFFFF_FFF0);
    rd(8'h28, 32'h0);
    xfer(1'b1, GIED_ADDR_CTRL, 32'h0);
    rq(OP_RD_TS, 32'h0, 64'h0, DW_REG64, OUT_NORMAL);
    chk(resp.data, 64'h0000_0001_FFFF_FFF0);
    rq(OP_NONE, 32'h0, 64'h0, DW_REG64, OUT_NORMAL);
    chk(resp.data, 64'h0);
    rq(OP_RD_TS_PAIR, 32'h0, 64'h0, DW_REG64, OUT_INV_OPCODE);
    xfer(1'b1, GIED_ADDR_CTRL, 32'h0000_0003);
    rq(OP_RD_TS, 32'h0, 64'h0, DW_REG64, OUT_EXIT);
    rq(OP_RD_TS_PAIR, 32'h0, 64'h0, DW_REG64, OUT_INV_OPCODE);
    xfer(1'b1, GIED_ADDR_CTRL, 32'h0000_0002);
    rq(OP_RD_TS, 32'h0, 64'h0, DW_REG64, OUT_ALTERED);
    chk(resp.data, 64'h0000_0001_FFFF_FFE0);
    rq(OP_MREG_RD, GIED_MREG_DEADLINE, 64'h0, DW_REG64, OUT_NORMAL);
    chk(resp.data, 64'h0000_0005_0000_0000);
    rq(OP_MREG_RD, GIED_MREG_TSC, 64'h0, DW_REG64, OUT_ALTERED);
    chk(resp.data, 64'h0000_0001_FFFF_FFE0);
    xfer(1'b1, GIED_ADDR_CTRL, 32'h0000_0006);
    rq(OP_RD_TS_PAIR, 32'h0, 64'h0, DW_REG64, OUT_ALTERED);
    chk({resp.data, resp.count, resp.count_we}, {64'h0000_0001_FFFF_FFE0, 32'h1234_5678, 1'b1});
    xfer(1'b1, GIED_ADDR_CTRL, 32'h0000_0005);
    rq(OP_RD_TS_PAIR, 32'h0, 64'h0, DW_REG64, OUT_EXIT);
    xfer(1'b1, GIED_ADDR_CTRL, 32'h0000_0004);
    rq(OP_RD_TS_PAIR, 32'h0, 64'h0, DW_REG64, OUT_NORMAL);
    rq(OP_MREG_WR, GIED_MREG_UCODE, 64'h0, DW_REG64, OUT_ALTERED);
    chk(resp.ucode_load, 1'b0);
    rq(OP_MREG_RD, GIED_MREG_LOCAL_INTERRUPT_CONTROLLER_LO, 64'h0, DW_REG64, OUT_NORMAL);
    chk(resp.data, 64'h0000_0000_0000_5555);
    rq(OP_MREG_WR, GIED_MREG_EOI, 64'h0, DW_REG64, OUT_NORMAL);
    xfer(1'b1, GIED_ADDR_CTRL, 32'h0000_0040);
    rq(OP_MREG_RD, GIED_MREG_LOCAL_INTERRUPT_CONTROLLER_LO, 64'h0, DW_REG64, OUT_LOCAL_INTERRUPT_CONTROLLER_VIRT);
    rq(OP_MREG_RD, GIED_MREG_LOCAL_INTERRUPT_CONTROLLER_HI, 64'h0, DW_REG64, OUT_LOCAL_INTERRUPT_CONTROLLER_VIRT);
    rq(OP_MREG_RD, 32'h0000_0900, 64'h0, DW_REG64, OUT_NORMAL);
    rq(OP_MREG_WR, GIED_MREG_TPR, 64'h0, DW_REG64, OUT_LOCAL_INTERRUPT_CONTROLLER_VIRT);
    rq(OP_MREG_WR, GIED_MREG_EOI, 64'h0, DW_REG64, OUT_LOCAL_INTERRUPT_CONTROLLER_VIRT);
    rq(OP_MREG_WR, GIED_MREG_SELF, 64'h0, DW_REG64, OUT_LOCAL_INTERRUPT_CONTROLLER_VIRT);
    $display("test timestamp and model registers done");
    mk = 64'h00F0_0000_FF00_FF0F; sh = 64'hAAAA_AAAA_5555_5555;
    xfer(1'b1, GIED_ADDR_MASK_LO, mk[31:0]);
    xfer(1'b1, GIED_ADDR_MASK_HI, mk[63:32]);
    xfer(1'b1, GIED_ADDR_SHD_LO, sh[31:0]);
    xfer(1'b1, GIED_ADDR_SHD_HI, sh[63:32]);
    m = (mstate.cr0 & ~mk) | (sh & mk);
    for (int w = 0; w < 4; w++) begin
      rq(OP_STORE_MW, 32'h0, 64'h0, gied_dwidth_t'(w), OUT_ALTERED);
      if (w < 2) chk(resp.data, {old[63:16], m[15:0]});
      else if (w == 2) chk(resp.data, {32'h0, m[31:0]});
      else chk(resp.data, m);
    end
    $display("test machine word store done");
    xfer(1'b1, GIED_ADDR_XBM_LO, 32'h0000_0100);
    xfer(1'b1, GIED_ADDR_CTRL, 32'h0);
    rq(OP_SUP_SAVE, 32'h0, 64'hFFFF, DW_REG64, OUT_INV_OPCODE);
    rq(OP_SUP_RESTORE, 32'h0, 64'hFFFF, DW_REG64, OUT_INV_OPCODE);
    xfer(1'b1, GIED_ADDR_CTRL, 32'h0000_0008);
    rq(OP_SUP_SAVE, 32'h0, 64'h0000_0100, DW_REG64, OUT_EXIT);
    rq(OP_SUP_RESTORE, 32'h0, 64'h0000_0200, DW_REG64, OUT_NORMAL);
    rq(OP_SUP_RESTORE, 32'h0, 64'h0000_0300, DW_REG64, OUT_EXIT);
    $display("test supervisor state done");
    ts(TS_HW_GATE, 7'b1111111, OUT_GP_FAULT);
    ts(TS_DIRECT, 7'b1111111, OUT_GP_FAULT);
    ts(TS_RET_NESTED, 7'b1111111, OUT_GP_FAULT);
    ts(TS_SW_GATE, 7'b0110111, OUT_EXIT);
    ts(TS_SW_GATE, 7'b0101111, OUT_GP_FAULT);
    ts(TS_BPOF_GATE, 7'b0101111, OUT_GP_FAULT);
    ts(TS_DIRECT, 7'b0110111, OUT_GP_FAULT);
    ts(TS_HW_GATE, 7'b0100111, OUT_EXIT);
    ts(TS_RET_NESTED, 7'b0100111, OUT_EXIT);
    ts(TS_SW_GATE, 7'b0011111, OUT_GP_FAULT);
    ts(TS_HW_GATE, 7'b0111000, OUT_GP_FAULT);
    ts(TS_SW_GATE, 7'b0111100, OUT_PAGE_FAULT);
    ts(TS_RET_NESTED, 7'b0111110, OUT_GP_FAULT);
    ts(TS_HW_GATE, 7'b0111111, OUT_EXIT);
    rd(GIED_ADDR_STATUS, {13'h0, OUT_EXIT, 16'(n_exit)});
    $display("test task switch done");
    ev(1'b1, 1'b1, 1'b0, 4'b1010);
    xfer(1'b1, GIED_ADDR_CTRL, 32'h0000_0030);
    ev(1'b1, 1'b0, 1'b0, 4'b0101);
    ev(1'b1, 1'b0, 1'b1, 4'b0000);
    stack_load_shadow <= 1'b1;
    ev(1'b1, 1'b0, 1'b0, 4'b0000);
    stack_load_shadow <= 1'b0;
    ev(1'b0, 1'b1, 1'b0, 4'b0000);
    $display("test event blocking done");
    summarize();
  end
endmodule // gied_top_bench
